/* File: core/irq_expand_pkg.sv */
// constants, field layouts and carrier types of the interrupt expansion block
// assumes a single 125 MHz system clock shared by every user of this package
package irq_expand_pkg;

  // source organisation
  localparam int NUM_SOURCES = 96;
  localparam int GROUP_SIZE = 8;
  localparam int NUM_GROUPS = 12;
  localparam int NUM_EXT = 3;
  localparam int USED_SOURCES_DEF = 43;
  localparam int GPIO_W_DEF = 32;

  // widths
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int VEC_W = 32;
  localparam int CNT_W = 16;
  localparam int SRC_W = 7;
  localparam int GRP_W = 4;
  localparam int SEL_W = 5;

  // vector fetch plus context save occupies the core this many cycles
  localparam int FETCH_CYCLES = 8;
  localparam int FCNT_W = $clog2(FETCH_CYCLES);

  // fixed slots of on-chip events inside the expansion block
  localparam int EXT_A_SLOT = 3;
  localparam int EXT_B_SLOT = 4;
  localparam int TIMER0_SLOT = 6;

  // register word addresses
  localparam logic [ADDR_W-1:0] VEC_BASE = 9'h000;
  localparam logic [ADDR_W-1:0] ENABLE_BASE = 9'h080;
  localparam logic [ADDR_W-1:0] PENDING_BASE = 9'h090;
  localparam logic [ADDR_W-1:0] EXT_CTRL_BASE = 9'h0A0;
  localparam logic [ADDR_W-1:0] EXT_CNT_BASE = 9'h0A4;
  localparam logic [ADDR_W-1:0] ROUTE_REG = 9'h0A8;
  localparam logic [ADDR_W-1:0] STATUS_REG = 9'h0A9;

  // external channel control fields
  localparam int EXT_EN_BIT = 0;
  localparam int EXT_POL_LSB = 1;
  localparam int EXT_SEL_LSB = 8;
  localparam logic [1:0] POL_FALL = 2'h0;
  localparam logic [1:0] POL_RISE = 2'h1;

  // route register fields
  localparam int ROUTE_W = 2;
  localparam int ROUTE_NMI_TO_13_BIT = 0;
  localparam int ROUTE_T1_EN_BIT = 1;
  localparam logic [ROUTE_W-1:0] ROUTE_RST = 2'h0;

  // status register fields
  localparam int STATUS_BUSY_BIT = 12;

  typedef enum logic [1:0] {SLEEP_RUN, SLEEP_LIGHT, SLEEP_GATED} sleep_mode_t;
  typedef enum logic {FETCH_IDLE, FETCH_BUSY} fetch_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic valid;
    logic empty;
    logic [SRC_W-1:0] src;
    logic [VEC_W-1:0] vector;
  } vec_ans_t;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic [1:0] pol;
    logic en;
  } ext_ctrl_t;

endpackage : irq_expand_pkg

/* File: core/irq_expand.sv */
// interrupt expansion block, external edge channels and timer line routing
// assumes peripheral and timer requests are one-cycle pulses on i_clk and
// port a pins are asynchronous; the core issues each fetch itself
`timescale 1ns/100ps

// Behaviour
// - up to 96 peripheral requests funnel onto fewer processor lines
// - eight sources form a group; twelve groups drive twelve cpu lines
// - every source owns a vector word that software may rewrite anytime
// - core fetches vector unaided; fetch and save occupy eight cycles
// - each source has its own enable bit
// - fixed lowest-slot-first order inside a group plus software masks
// - only the first 43 slots are wired; the rest stay dead
// - three external channels: two general, one nonmaskable-capable
// - third channel goes to line thirteen or the nonmaskable input
// - each channel triggers on falling, rising or both edges
// - each channel has an enable that suppresses its requests
// - 16-bit free-running counter per channel clears on qualifying edge
// - any port a pin may feed any channel; no dedicated pins
// - third timer drives line fourteen directly
// - second timer may drive line thirteen, shared with third channel
// - first timer enters the expansion block as a grouped source
// - light sleep: enabled interrupt or watchdog wakes the core
// - gated sleep: external event restarts clocks on next cycle
module irq_expand
  import irq_expand_pkg::*;
#(
  parameter int USED_SOURCES = USED_SOURCES_DEF,
  parameter int GPIO_W = GPIO_W_DEF
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // register port
  input wire bus_req_t i_bus,
  output logic [DATA_W-1:0] o_rdata,
  // interrupt sources
  input wire logic [NUM_SOURCES-1:0] i_periph_irq,
  input wire logic i_timer0_irq,
  input wire logic i_timer1_irq,
  input wire logic i_timer2_irq,
  input wire logic i_watchdog_irq,
  input wire logic [GPIO_W-1:0] i_gpio_a,
  // processor side
  output logic [NUM_GROUPS-1:0] o_cpu_group_lines,
  output logic o_cpu_line_thirteen,
  output logic o_cpu_line_fourteen,
  output logic o_nmi,
  input wire logic i_fetch,
  input wire logic [GRP_W-1:0] i_fetch_group,
  output vec_ans_t o_vec,
  output logic o_fetch_busy,
  // power management
  input wire sleep_mode_t i_sleep_mode,
  output logic o_wake
);

  // elaboration checks
  if (GROUP_SIZE * NUM_GROUPS != NUM_SOURCES || GROUP_SIZE != 8)
    $error("group layout does not cover the source count");
  if (USED_SOURCES <= TIMER0_SLOT || USED_SOURCES > NUM_SOURCES)
    $error("USED_SOURCES out of range");
  if (GPIO_W < 1 || GPIO_W > 32)
    $error("GPIO_W must lie in 1..32");

  // dead slots never pend and never enable
  localparam logic [NUM_SOURCES-1:0] USED_MASK =
    {NUM_SOURCES{1'b1}} >> (NUM_SOURCES - USED_SOURCES);

  typedef struct packed {
    logic [GPIO_W-1:0] sync1;
    logic [GPIO_W-1:0] sync2;
    logic [NUM_EXT-1:0] prev;
    logic [NUM_EXT-1:0][CNT_W-1:0] cnt;
    ext_ctrl_t [NUM_EXT-1:0] ctrl;
    logic [NUM_SOURCES-1:0] pending;
    logic [NUM_SOURCES-1:0] enable;
    logic [NUM_GROUPS-1:0] group_line;
    logic line13;
    logic line14;
    logic nmi;
    logic wake;
    logic [ROUTE_W-1:0] route;
    fetch_state_t fstate;
    logic [FCNT_W-1:0] fcount;
    vec_ans_t vec;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t st;
  state_t next;
  logic [VEC_W-1:0] vec_table [NUM_SOURCES];
  logic [NUM_EXT-1:0] ext_cur;
  logic [NUM_EXT-1:0] ext_hit;
  logic [NUM_SOURCES-1:0] src_event;
  logic fetch_take;

  // lowest set slot wins inside a group
  function automatic logic [2:0] first_set(input logic [7:0] bits);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (bits[i])
        idx = 3'(i);
    return idx;
  endfunction : first_set

  // edge qualifier shared by all channels
  function automatic logic edge_hit(input logic [1:0] pol, input logic cur,
                                    input logic prev);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    if (pol == POL_FALL)
      return fall;
    else if (pol == POL_RISE)
      return rise;
    else
      return rise | fall;
  endfunction : edge_hit

  // window test shared by read and write decode
  function automatic logic in_range(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] base,
                                    input int count);
    return (addr >= base) && (int'(addr) < int'(base) + count);
  endfunction : in_range

  // channel edge detection on the second sync stage only
  for (genvar c = 0; c < NUM_EXT; c++)
  begin : g_ext
    assign ext_cur[c] = (int'(st.ctrl[c].sel) < GPIO_W) ?
                        st.sync2[st.ctrl[c].sel] : 1'b0;
    assign ext_hit[c] = st.ctrl[c].en &
                        edge_hit(st.ctrl[c].pol, ext_cur[c],
                                 st.prev[c]);
  end

  // request sources into the grouped slots
  always_comb
  begin
    src_event = i_periph_irq & USED_MASK;
    src_event[TIMER0_SLOT] = src_event[TIMER0_SLOT] | i_timer0_irq;
    src_event[EXT_A_SLOT] = src_event[EXT_A_SLOT] | ext_hit[0];
    src_event[EXT_B_SLOT] = src_event[EXT_B_SLOT] | ext_hit[1];
  end

  // a fetch is taken only when idle and for an existing group
  assign fetch_take = i_fetch && (st.fstate == FETCH_IDLE) &&
                      (int'(i_fetch_group) < NUM_GROUPS);

  // whole next state
  always_comb
  begin
    logic [NUM_SOURCES-1:0] clr;
    logic [7:0] gbits;
    logic [2:0] idx;
    logic [ADDR_W-1:0] off;
    logic [DATA_W-1:0] word;
    clr = '0;
    gbits = 8'h00;
    idx = 3'h0;
    off = '0;
    word = '0;
    next = st;
    // two-stage pin synchroniser
    next.sync1 = i_gpio_a;
    next.sync2 = st.sync1;
    for (int c = 0; c < NUM_EXT; c++)
    begin
      next.prev[c] = ext_cur[c];
      next.cnt[c] = ext_hit[c] ? '0 : st.cnt[c] + 16'h1;
    end
    // vector fetch sequencer
    next.vec.valid = 1'b0;
    case (st.fstate)
      FETCH_IDLE:
        if (fetch_take)
        begin
          gbits = st.pending[{i_fetch_group, 3'h0} +: 8] &
                  st.enable[{i_fetch_group, 3'h0} +: 8];
          idx = first_set(gbits);
          next.vec.valid = 1'b1;
          next.vec.empty = ~|gbits;
          next.vec.src = {i_fetch_group, idx};
          next.vec.vector = (|gbits) ? vec_table[{i_fetch_group, idx}] : '0;
          clr[{i_fetch_group, idx}] = |gbits; // fetch acknowledges
          next.fstate = FETCH_BUSY;
          next.fcount = FCNT_W'(FETCH_CYCLES - 1);
        end
      FETCH_BUSY:
        if (st.fcount == '0)
          next.fstate = FETCH_IDLE;
        else
          next.fcount = st.fcount - 3'h1;
      default:
        next.fstate = FETCH_IDLE;
    endcase
    // register writes
    if (i_bus.wr)
    begin
      if (in_range(i_bus.addr, ENABLE_BASE, NUM_GROUPS))
      begin
        off = i_bus.addr - ENABLE_BASE;
        next.enable[{off[3:0], 3'h0} +: 8] =
          i_bus.wdata[7:0] & USED_MASK[{off[3:0], 3'h0} +: 8];
      end
      else if (in_range(i_bus.addr, PENDING_BASE, NUM_GROUPS))
      begin
        off = i_bus.addr - PENDING_BASE;
        clr[{off[3:0], 3'h0} +: 8] =
          clr[{off[3:0], 3'h0} +: 8] | i_bus.wdata[7:0];
      end
      else if (in_range(i_bus.addr, EXT_CTRL_BASE, NUM_EXT))
      begin
        off = i_bus.addr - EXT_CTRL_BASE;
        next.ctrl[off[1:0]].en = i_bus.wdata[EXT_EN_BIT];
        next.ctrl[off[1:0]].pol = i_bus.wdata[EXT_POL_LSB +: 2];
        next.ctrl[off[1:0]].sel = i_bus.wdata[EXT_SEL_LSB +: SEL_W];
      end
      else if (i_bus.addr == ROUTE_REG)
        next.route = i_bus.wdata[ROUTE_W-1:0];
    end
    // register reads, answered in the following cycle
    next.rdata = '0;
    if (i_bus.rd)
    begin
      if (int'(i_bus.addr) < NUM_SOURCES)
        next.rdata = vec_table[i_bus.addr[SRC_W-1:0]];
      else if (in_range(i_bus.addr, ENABLE_BASE, NUM_GROUPS))
      begin
        off = i_bus.addr - ENABLE_BASE;
        next.rdata[7:0] = st.enable[{off[3:0], 3'h0} +: 8];
      end
      else if (in_range(i_bus.addr, PENDING_BASE, NUM_GROUPS))
      begin
        off = i_bus.addr - PENDING_BASE;
        next.rdata[7:0] = st.pending[{off[3:0], 3'h0} +: 8];
      end
      else if (in_range(i_bus.addr, EXT_CTRL_BASE, NUM_EXT))
      begin
        off = i_bus.addr - EXT_CTRL_BASE;
        word[EXT_EN_BIT] = st.ctrl[off[1:0]].en;
        word[EXT_POL_LSB +: 2] = st.ctrl[off[1:0]].pol;
        word[EXT_SEL_LSB +: SEL_W] = st.ctrl[off[1:0]].sel;
        next.rdata = word;
      end
      else if (in_range(i_bus.addr, EXT_CNT_BASE, NUM_EXT))
      begin
        off = i_bus.addr - EXT_CNT_BASE;
        next.rdata[CNT_W-1:0] = st.cnt[off[1:0]]; // timestamp readout
      end
      else if (i_bus.addr == ROUTE_REG)
        next.rdata[ROUTE_W-1:0] = st.route;
      else if (i_bus.addr == STATUS_REG)
      begin
        next.rdata[NUM_GROUPS-1:0] = st.group_line;
        next.rdata[STATUS_BUSY_BIT] = (st.fstate == FETCH_BUSY);
      end
    end
    // a new request beats a clear in the same cycle
    next.pending = (st.pending & ~clr) | src_event;
    for (int g = 0; g < NUM_GROUPS; g++)
      next.group_line[g] = |(next.pending[g*GROUP_SIZE +: GROUP_SIZE] &
                             next.enable[g*GROUP_SIZE +: GROUP_SIZE]);
    // direct lines bypass the groups
    next.line13 = (i_timer1_irq & st.route[ROUTE_T1_EN_BIT]) |
                  (ext_hit[2] & st.route[ROUTE_NMI_TO_13_BIT]);
    next.nmi = ext_hit[2] & ~st.route[ROUTE_NMI_TO_13_BIT];
    next.line14 = i_timer2_irq;
    // wake request toward the clock controller
    next.wake = ((i_sleep_mode == SLEEP_LIGHT) &&
                 ((|next.group_line) || i_watchdog_irq ||
                  next.line13 || next.line14 || next.nmi)) ||
                ((i_sleep_mode == SLEEP_GATED) && (|ext_hit));
  end

  // state register; every field resets to zero, the route through its default ROUTE_RST, which is zero as well
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st <= '0;
      st.route <= ROUTE_RST;
    end
    else
      st <= next;
  end

  // vector words, no reset: software must load them before enabling
  always_ff @(posedge i_clk)
  begin
    if (i_bus.wr && int'(i_bus.addr) < NUM_SOURCES)
      vec_table[i_bus.addr[SRC_W-1:0]] <= i_bus.wdata;
  end

  // outputs
  assign o_rdata = st.rdata;
  assign o_cpu_group_lines = st.group_line;
  assign o_cpu_line_thirteen = st.line13;
  assign o_cpu_line_fourteen = st.line14;
  assign o_nmi = st.nmi;
  assign o_vec = st.vec;
  assign o_fetch_busy = (st.fstate == FETCH_BUSY);
  assign o_wake = st.wake;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_answer;
    o_vec.valid ##0 o_fetch_busy [*8] ##1 !o_fetch_busy;
  endsequence

  sequence s_edge_seen(int c);
    ext_hit[c] ##1 (st.cnt[c] == 16'h0000);
  endsequence

  fetch_window_a: assert property (fetch_take |=> s_answer)
    else $error("fetch answer or busy window wrong");

  group_line_a: assert property (
    o_cpu_group_lines[0] == |(st.pending[7:0] & st.enable[7:0]))
    else $error("group line disagrees with pending and enable");

  cnt_clear_a: assert property (ext_hit[0] |-> s_edge_seen(0))
    else $error("counter not cleared by qualifying edge");

  cnt_run_a: assert property (
    !ext_hit[1] |=> st.cnt[1] == $past(st.cnt[1]) + 16'h1)
    else $error("counter did not advance");

  line_fourteen_a: assert property (
    i_timer2_irq |=> o_cpu_line_fourteen)
    else $error("third timer missed line fourteen");

  nmi_route_a: assert property (
    ext_hit[2] |=> (o_nmi != o_cpu_line_thirteen) ||
                   (o_cpu_line_thirteen && $past(i_timer1_irq)))
    else $error("third channel routed to neither or both");

  dead_slots_a: assert property (
    (st.enable & ~USED_MASK) == '0 && (st.pending & ~USED_MASK) == '0)
    else $error("unused slot became active");

  fetch_ack_a: assert property (
    fetch_take && (|(st.pending[{i_fetch_group, 3'h0} +: 8] &
                     st.enable[{i_fetch_group, 3'h0} +: 8]))
    && !src_event[{i_fetch_group, first_set(
         st.pending[{i_fetch_group, 3'h0} +: 8] &
         st.enable[{i_fetch_group, 3'h0} +: 8])}]
    |=> !st.pending[o_vec.src] && !o_vec.empty)
    else $error("fetched request not acknowledged");

  set_wins_a: assert property (
    src_event[TIMER0_SLOT] |=> st.pending[TIMER0_SLOT])
    else $error("request lost against a clear");

  gated_wake_a: assert property (
    (i_sleep_mode == SLEEP_GATED) && (|ext_hit) |=> o_wake)
    else $error("external event did not wake from gated sleep");

  // a new enabled request must raise its line unless a register write falls in the same cycle
  group_rise_a: assert property (
    (|(src_event[7:0] & st.enable[7:0])) && !i_bus.wr
    |=> o_cpu_group_lines[0])
    else $error("enabled request did not raise its group line");

  line_thirteen_a: assert property (
    i_timer1_irq && st.route[ROUTE_T1_EN_BIT] |=> o_cpu_line_thirteen)
    else $error("second timer missed line thirteen");

  busy_refuse_a: assert property (
    i_fetch && o_fetch_busy |=> !o_vec.valid)
    else $error("fetch answered while the window was busy");

  // read data stand for one cycle only, zero otherwise
  rdata_idle_a: assert property (!i_bus.rd |=> o_rdata == '0)
    else $error("read data present without a read");

endmodule : irq_expand

/* File: sim/core_fetch_model.sv */
// behavioural processor core: watches the group lines and fetches vectors
// assumes the expansion block on the same clock; the bench may ask by hand
`timescale 1ns/100ps
module core_fetch_model
  import irq_expand_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // bench control
  input wire logic i_auto,
  input wire logic [3:0] i_delay,
  input wire logic i_req,
  input wire logic [GRP_W-1:0] i_req_group,
  // expansion block side
  input wire logic [NUM_GROUPS-1:0] i_lines,
  input wire logic i_busy,
  input wire vec_ans_t i_vec,
  output logic o_fetch,
  output logic [GRP_W-1:0] o_group,
  output logic [7:0] o_taken
);
  typedef enum logic [1:0] {M_IDLE, M_REQ, M_WAIT} mstate_t;
  mstate_t st;
  logic [3:0] dly;
  logic [GRP_W-1:0] grp;
  logic [GRP_W-1:0] low;

  // lowest active group is served first
  always_comb
  begin
    low = '0;
    for (int g = NUM_GROUPS - 1; g >= 0; g--)
      if (i_lines[g])
        low = GRP_W'(g);
  end

  // one request, then wait for the answer and for busy to fall
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st <= M_IDLE;
      dly <= '0;
      grp <= '0;
      o_taken <= '0;
    end
    else if (st == M_REQ)
      st <= M_WAIT;
    else if (st == M_WAIT)
    begin
      if (i_vec.valid)
      begin
        st <= M_IDLE;
        o_taken <= o_taken + 8'h01;
      end
    end
    else if (i_auto && |i_lines && !i_busy)
    begin
      // a slow core lets i_delay cycles pass before it asks
      if (dly == i_delay)
      begin
        st <= M_REQ;
        grp <= low;
        dly <= '0;
      end
      else
        dly <= dly + 4'h1;
    end
  end

  // in auto mode never asks while busy, so the eight-cycle window is respected; by hand i_req passes through unchecked
  assign o_fetch = i_auto ? (st == M_REQ) : i_req;
  assign o_group = i_auto ? grp : i_req_group;
endmodule : core_fetch_model

/* File: sim/testbench.sv */
// self-checking bench of the interrupt expansion block
// assumes core_fetch_model on the far side and a 125 MHz clock
`timescale 1ns/100ps
module testbench;
  import irq_expand_pkg::*;
  typedef struct {int src; logic [7:0] en; logic [7:0] pend; logic ln;} row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  bus_req_t bus = '0;
  logic [DATA_W-1:0] rdata;
  logic [NUM_SOURCES-1:0] periph = '0;
  logic [3:0] tmr = '0;
  logic [31:0] gpio = '0;
  logic [NUM_GROUPS-1:0] lines;
  logic l13, l14, nmi, fetch, busy, wake;
  logic [GRP_W-1:0] fgrp;
  vec_ans_t vec;
  sleep_mode_t sleep = SLEEP_RUN;
  logic autom = 1'b0;
  logic req = 1'b0;
  logic [3:0] delay = 4'h0;
  logic [GRP_W-1:0] rgrp = '0;
  logic [7:0] taken;
  int miscompares = 0;
  int total_checks = 0;
  int n_val = 0, n_busy = 0, n_nmi = 0, n_13 = 0, n_14 = 0, n_wake = 0;
  int s0, s1, g;
  logic [31:0] d;
  row_t rows [6] = '{'{0, 8'hFF, 8'h01, 1'b1}, '{9, 8'h02, 8'h02, 1'b1},
    '{10, 8'h01, 8'h04, 1'b0}, '{42, 8'hFF, 8'h04, 1'b1},
    '{43, 8'hFF, 8'h00, 1'b0}, '{95, 8'hFF, 8'h00, 1'b0}};

  irq_expand dut (.i_clk(clk), .i_arst_n(arst_n), .i_bus(bus),
    .o_rdata(rdata), .i_periph_irq(periph), .i_timer0_irq(tmr[0]),
    .i_timer1_irq(tmr[1]), .i_timer2_irq(tmr[2]), .i_watchdog_irq(tmr[3]),
    .i_gpio_a(gpio), .o_cpu_group_lines(lines), .o_cpu_line_thirteen(l13),
    .o_cpu_line_fourteen(l14), .o_nmi(nmi), .i_fetch(fetch),
    .i_fetch_group(fgrp), .o_vec(vec), .o_fetch_busy(busy),
    .i_sleep_mode(sleep), .o_wake(wake));
  core_fetch_model core (.i_clk(clk), .i_arst_n(arst_n), .i_auto(autom),
    .i_delay(delay), .i_req(req), .i_req_group(rgrp), .i_lines(lines),
    .i_busy(busy), .i_vec(vec), .o_fetch(fetch), .o_group(fgrp),
    .o_taken(taken));

  // 125 MHz system clock
  initial
  begin
    forever #4 clk = ~clk;
  end

  // pulse counters on the falling edge, away from the launching edge
  always @(negedge clk)
  begin
    n_val += int'(vec.valid === 1'b1);
    n_busy += int'(busy === 1'b1);
    n_nmi += int'(nmi === 1'b1);
    n_13 += int'(l13 === 1'b1);
    n_14 += int'(l14 === 1'b1);
    n_wake += int'(wake === 1'b1);
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk) bus <= '{1'b1, 1'b0, a, v};
    @(posedge clk) bus <= '0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk) bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk) bus <= '0;
    #1 d = rdata;
  endtask : rd

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    rd(a);
    chk_word(d, e);
  endtask : rchk

  // holding the request longer tests that a busy block refuses it
  task automatic fetch_grp(input logic [GRP_W-1:0] gr, input int hold,
                           input int n);
    s0 = n_val;
    s1 = n_busy;
    @(posedge clk) req <= 1'b1;
    rgrp <= gr;
    repeat (hold) @(posedge clk);
    req <= 1'b0;
    tick(12);
    chk_word(32'(n_val - s0), 32'(n));
    chk_word(32'(n_busy - s1), 32'(8 * n));
  endtask : fetch_grp

  task automatic pin(input int p, input logic v);
    @(posedge clk) gpio[p] <= v;
    tick(6);
  endtask : pin

  task automatic kick(input int b);
    @(posedge clk) tmr[b] <= 1'b1;
    @(posedge clk) tmr <= '0;
    tick(3);
  endtask : kick

  function automatic logic [31:0] ctl(logic en, logic [1:0] pol, int sel);
    return {19'h0, 5'(sel), 5'h0, pol, en};
  endfunction : ctl

  // a hang is cut short after 100000 cycles
  initial
  begin
    #800000;
    miscompares++;
    end_of_test();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1 chk_word(32'({lines, l13, l14, nmi, busy, wake}), 32'h0);
    rchk(ROUTE_REG, 32'h0);
    rchk(EXT_CTRL_BASE, 32'h0);
    rchk(9'h1FF, 32'h0);
    // ordinary cases: one source pulse under its group's enable
    foreach (rows[i])
    begin
      g = rows[i].src / GROUP_SIZE;
      wr(ENABLE_BASE + 9'(g), 32'(rows[i].en));
      @(posedge clk) periph[rows[i].src] <= 1'b1;
      @(posedge clk) periph <= '0;
      rchk(PENDING_BASE + 9'(g), 32'(rows[i].pend));
      rchk(STATUS_REG, 32'(rows[i].ln) << g);
      wr(PENDING_BASE + 9'(g), 32'hFF);
    end
    wr(ENABLE_BASE + 9'h5, 32'hFF);
    rchk(ENABLE_BASE + 9'h5, 32'h07);
    wr(ENABLE_BASE + 9'h5, 32'h0);
    // two requests in one group, the lower slot answers first
    wr(VEC_BASE + 9'h9, 32'hA5A50009);
    wr(VEC_BASE + 9'hA, 32'h5A5A000A);
    wr(ENABLE_BASE + 9'h1, 32'h06);
    @(posedge clk) periph[10:9] <= 2'h3;
    @(posedge clk) periph <= '0;
    fetch_grp(4'h1, 3, 1);
    chk_word(32'(vec.src), 32'h9);
    chk_word(vec.vector, 32'hA5A50009);
    rchk(STATUS_REG, 32'h2);
    @(posedge clk) autom <= 1'b1;
    delay <= 4'h5;
    s0 = 0;
    while (taken === 8'h00 && s0 < 40)
    begin
      @(posedge clk);
      s0++;
    end
    if (s0 == 40)
    begin
      miscompares++;
      end_of_test();
    end
    tick(10);
    autom <= 1'b0;
    chk_word(32'(vec.src), 32'hA);
    chk_word(vec.vector, 32'h5A5A000A);
    rchk(STATUS_REG, 32'h0);
    wr(VEC_BASE + 9'h9, 32'h12345678);
    rchk(VEC_BASE + 9'h9, 32'h12345678);
    fetch_grp(4'h1, 1, 1);
    chk_word(32'(vec.empty), 32'h1);
    fetch_grp(4'hC, 1, 0);
    // channel a on several pins with every edge mode
    wr(ENABLE_BASE, 32'h08);
    for (int p = 0; p < 3; p++)
      for (int e = 0; e < 2; e++)
      begin
        wr(EXT_CTRL_BASE, ctl(1'b1, 2'(p), 3 + 7 * p + e));
        pin(3 + 7 * p + e, !e);
        wr(PENDING_BASE, 32'hFF);
        tick(50);
        pin(3 + 7 * p + e, e[0]);
        rchk(PENDING_BASE, (p == 2 || p == e) ? 32'h8 : 32'h0);
        rd(EXT_CNT_BASE);
        if (p == 2)
          chk_word(32'(d < 32'd40), 32'h1);
      end
    wr(EXT_CTRL_BASE, ctl(1'b0, POL_RISE, 25));
    wr(PENDING_BASE, 32'hFF);
    pin(25, 1'b1);
    rchk(PENDING_BASE, 32'h0);
    tick(30);
    rd(EXT_CNT_BASE);
    chk_word(32'(d > 32'd30), 32'h1);
    // channel b on the top pin, falling edges only
    wr(EXT_CTRL_BASE + 9'h1, ctl(1'b1, POL_FALL, 31));
    pin(31, 1'b1);
    pin(31, 1'b0);
    rchk(PENDING_BASE, 32'h10);
    wr(PENDING_BASE, 32'hFF);
    // third channel to the nonmaskable input, then to line thirteen
    wr(EXT_CTRL_BASE + 9'h2, ctl(1'b1, POL_RISE, 0));
    s0 = n_nmi;
    pin(0, 1'b1);
    chk_word(32'(n_nmi - s0), 32'h1);
    wr(ROUTE_REG, 32'h1);
    pin(0, 1'b0);
    s0 = n_13;
    pin(0, 1'b1);
    chk_word(32'(n_13 - s0), 32'h1);
    chk_word(32'(n_wake), 32'h0);
    // timer lines
    s0 = n_14;
    s1 = n_13;
    kick(2);
    kick(1);
    chk_word(32'(n_14 - s0), 32'h1);
    chk_word(32'(n_13 - s1), 32'h0);
    wr(ROUTE_REG, 32'h2);
    kick(1);
    chk_word(32'(n_13 - s1), 32'h1);
    wr(ENABLE_BASE, 32'h40);
    kick(0);
    rchk(PENDING_BASE, 32'h40);
    // wake from both sleep modes
    @(posedge clk) sleep <= SLEEP_LIGHT;
    s0 = n_wake;
    tick(3);
    chk_word(32'(n_wake > s0), 32'h1);
    wr(PENDING_BASE, 32'hFF);
    tick(3);
    s0 = n_wake;
    kick(3);
    chk_word(32'(n_wake > s0), 32'h1);
    @(posedge clk) sleep <= SLEEP_GATED;
    pin(0, 1'b0);
    s0 = n_wake;
    pin(0, 1'b1);
    chk_word(32'(n_wake > s0), 32'h1);
    @(posedge clk) sleep <= SLEEP_RUN;
    // reset in mid-run returns route and channel controls to zero
    @(posedge clk) arst_n <= 1'b0;
    tick(2);
    arst_n <= 1'b1;
    @(posedge clk);
    #1 chk_word(32'({lines, l13, l14, nmi, busy, wake}), 32'h0);
    rchk(ROUTE_REG, 32'h0);
    rchk(EXT_CTRL_BASE + 9'h2, 32'h0);
    end_of_test();
  end
endmodule : testbench
